// *** shared/hsp_pkg.sv ***
// Constants and types shared by the handshake stream pipeline block.
// Assumes one clock and a single active-high asynchronous reset at the top.
package hsp_pkg;

	localparam int unsigned HSP_DATA_W      = 8;
	localparam int unsigned HSP_FIFO_DEPTH  = 2;
	localparam logic        HSP_VALID_RESET = 1'b0;

	typedef enum logic [2:0] {
		HSP_PATH_DIRECT,
		HSP_PATH_FORWARD,
		HSP_PATH_BACKWARD,
		HSP_PATH_HALF,
		HSP_PATH_COMBINED,
		HSP_PATH_QUEUED
	} hsp_path_t;

endpackage

// *** shared/hsp_stream_if.sv ***
// Valid/ready channel carrying one payload word between internal modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps

interface hsp_stream_if #(
	parameter int unsigned W = 8
);
	logic         valid;
	logic         ready;
	logic [W-1:0] data;

	modport source (output valid, output data, input ready);
	modport sink   (input valid, input data, output ready);
endinterface

// *** hdl/hsp_fifo.sv ***
// Ordered first-in first-out buffer between two valid/ready channels.
// Assumes the same clock on both sides; depth of at least one.
`timescale 1ns/1ps

module hsp_fifo
	import hsp_pkg::*;
#(
	parameter int unsigned W     = HSP_DATA_W,
	parameter int unsigned DEPTH = HSP_FIFO_DEPTH
) (
	input  wire logic   clk_i,
	input  wire logic   rst_i,
	hsp_stream_if.sink   push,
	hsp_stream_if.source pop
);
	localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [CW-1:0] cnt_q;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction

	wire full  = (cnt_q == CW'(DEPTH));
	wire empty = (cnt_q == '0);
	wire wr_en = push.valid && !full;
	wire rd_en = pop.ready && !empty;

	// Full and empty come straight from the count, so back-pressure is honest.
	assign push.ready = !full;
	assign pop.valid  = !empty;
	assign pop.data   = mem_q[rd_q];

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (wr_en) begin
				wr_q <= bump(wr_q);
			end
			if (rd_en) begin
				rd_q <= bump(rd_q);
			end
			cnt_q <= CW'(cnt_q + CW'(wr_en) - CW'(rd_en));
		end
	end

	always_ff @(posedge clk_i) begin
		if (wr_en) begin
			mem_q[wr_q] <= push.data;
		end
	end
endmodule

// *** hdl/hsp_pipeline.sv ***
// Stream pipeline: gates, a selectable register slice, and a queued output.
// Assumes producer and consumer logic run on CORE_CLK_I and keep their handshake.
`timescale 1ns/1ps

module hsp_pipeline
	import hsp_pkg::*;
#(
	parameter int unsigned W     = HSP_DATA_W,
	parameter int unsigned DEPTH = HSP_FIFO_DEPTH
) (
	input  wire logic         CORE_CLK_I,
	input  wire logic         RST_I,
	input  wire hsp_path_t    PATH_SEL_I,
	input  wire logic         HALT_I,
	input  wire logic         DROP_I,
	input  wire logic         IN_VALID_I,
	output logic              IN_READY_O,
	input  wire logic [W-1:0] IN_DATA_I,
	output logic              OUT_VALID_O,
	input  wire logic         OUT_READY_I,
	output logic [W-1:0]      OUT_DATA_O,
	output logic              IN_FIRE_O,
	output logic              IN_STALL_O,
	output logic              OUT_FIRE_O,
	output logic              OUT_STALL_O
);

	////////////////////////////////////////////////////////////////////////////
	// Halt and drop gates on the input channel.

	wire          g_valid;
	wire          g_ready;
	wire          halted  = HALT_I;
	wire          dropped = DROP_I && !HALT_I;

	// Halt wins over drop, so a halted channel neither takes nor discards words.
	assign IN_READY_O = halted ? 1'b0 : (dropped ? 1'b1 : g_ready);
	assign g_valid    = IN_VALID_I && !halted && !dropped;

	////////////////////////////////////////////////////////////////////////////
	// Path decode and handshake helpers.

	function automatic logic fire(input logic v, input logic r);
		return v && r;
	endfunction

	function automatic logic stall(input logic v, input logic r);
		return v && !r;
	endfunction

	function automatic logic path_is(input hsp_path_t sel, input hsp_path_t p);
		return sel == p;
	endfunction

	// Codes past the last path fall through to the direct connection.
	wire          sel_forward  = path_is(PATH_SEL_I, HSP_PATH_FORWARD);
	wire          sel_backward = path_is(PATH_SEL_I, HSP_PATH_BACKWARD);
	wire          sel_half     = path_is(PATH_SEL_I, HSP_PATH_HALF);
	wire          combined     = path_is(PATH_SEL_I, HSP_PATH_COMBINED);
	wire          queued       = path_is(PATH_SEL_I, HSP_PATH_QUEUED);

	////////////////////////////////////////////////////////////////////////////
	// Forward slice: registers valid and payload.

	logic         fw_valid_q;
	logic [W-1:0] fw_data_q;
	logic         fw_in_valid;
	logic [W-1:0] fw_in_data;
	logic         fw_out_ready;
	// A full slice refills in the cycle its word leaves, which keeps full throughput.
	wire          fw_in_ready = !fw_valid_q || fw_out_ready;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			fw_valid_q <= HSP_VALID_RESET;
			fw_data_q  <= '0;
		end else if (fw_in_ready) begin
			fw_valid_q <= fw_in_valid;
			fw_data_q  <= fw_in_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Backward slice: one skid register, ready is a flop output.

	logic         bw_skid_q;
	logic [W-1:0] bw_data_q;
	logic         bw_in_valid;
	logic [W-1:0] bw_in_data;
	logic         bw_out_ready;
	// Ready comes straight from the skid flop, so no combinational path runs from
	// the output ready back to the input ready.
	wire          bw_in_ready  = !bw_skid_q;
	wire          bw_out_valid = bw_in_valid || bw_skid_q;
	wire  [W-1:0] bw_out_data  = bw_skid_q ? bw_data_q : bw_in_data;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			bw_skid_q <= HSP_VALID_RESET;
			bw_data_q <= '0;
		end else begin
			if (bw_out_ready) begin
				bw_skid_q <= 1'b0;
			end else if (fire(bw_in_valid, bw_in_ready)) begin
				bw_skid_q <= 1'b1;
				bw_data_q <= bw_in_data;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Half slice, one word per three cycles at best: valid, ready and payload all registered.

	logic         hf_valid_q;
	logic         hf_ready_q;
	logic [W-1:0] hf_data_q;
	logic         hf_out_ready;

	always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			hf_valid_q <= HSP_VALID_RESET;
			hf_ready_q <= 1'b0;
			hf_data_q  <= '0;
		end else begin
			// Taking one word, then emptying and idling a cycle before the next, cuts bandwidth to a third.
			hf_ready_q <= 1'b0;
			if (hf_valid_q) begin
				if (hf_out_ready) begin
					hf_valid_q <= 1'b0;
				end
			end else if (sel_half && fire(g_valid, hf_ready_q)) begin
				// Only the half path loads this slice, so no stale word waits in it.
				hf_valid_q <= 1'b1;
				hf_data_q  <= IN_DATA_I;
			end else begin
				// Ready opens on every other idle cycle only.
				hf_ready_q <= !hf_ready_q;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Path selection.

	logic         sl_valid;
	logic [W-1:0] sl_data;
	logic         sl_ready;
	logic         sl_in_ready;

	assign bw_in_valid  = (sel_backward || combined) && g_valid;
	assign bw_in_data   = IN_DATA_I;
	assign bw_out_ready = combined ? fw_in_ready : sl_ready;
	assign fw_in_valid  = combined ? bw_out_valid : (sel_forward && g_valid);
	assign fw_in_data   = combined ? bw_out_data : IN_DATA_I;
	assign fw_out_ready = sl_ready;
	assign hf_out_ready = sl_ready;

	// Only the selected slice is offered words; the idle ones stay empty.
	always_comb begin
		case (PATH_SEL_I)
			HSP_PATH_FORWARD: begin
				sl_valid    = fw_valid_q;
				sl_data     = fw_data_q;
				sl_in_ready = fw_in_ready;
			end
			HSP_PATH_BACKWARD: begin
				sl_valid    = bw_out_valid;
				sl_data     = bw_out_data;
				sl_in_ready = bw_in_ready;
			end
			HSP_PATH_HALF: begin
				sl_valid    = hf_valid_q;
				sl_data     = hf_data_q;
				sl_in_ready = hf_ready_q;
			end
			HSP_PATH_COMBINED: begin
				sl_valid    = fw_valid_q;
				sl_data     = fw_data_q;
				sl_in_ready = bw_in_ready;
			end
			default: begin
				sl_valid    = g_valid;
				sl_data     = IN_DATA_I;
				sl_in_ready = sl_ready;
			end
		endcase
	end

	assign g_ready = sl_in_ready;

	////////////////////////////////////////////////////////////////////////////
	// Queued output; in direct modes the buffer is bypassed.

	hsp_stream_if #(.W(W)) q_in ();
	hsp_stream_if #(.W(W)) q_out ();

	assign q_in.valid = queued && g_valid;
	assign q_in.data  = IN_DATA_I;
	assign q_out.ready = queued && OUT_READY_I;

	hsp_fifo #(.W(W), .DEPTH(DEPTH)) u_fifo (
		.clk_i (CORE_CLK_I),
		.rst_i (RST_I),
		.push  (q_in),
		.pop   (q_out)
	);

	// Queue mode takes the input ready from the buffer, other modes from the slice.
	assign sl_ready    = queued ? q_in.ready : OUT_READY_I;
	assign OUT_VALID_O = queued ? q_out.valid : sl_valid;
	assign OUT_DATA_O  = queued ? q_out.data : sl_data;

	////////////////////////////////////////////////////////////////////////////
	// Transfer and stall indicators.

	// The indicators watch the pins, so they also show words that the drop gate swallows.
	assign IN_FIRE_O   = fire(IN_VALID_I, IN_READY_O);
	assign IN_STALL_O  = stall(IN_VALID_I, IN_READY_O);
	assign OUT_FIRE_O  = fire(OUT_VALID_O, OUT_READY_I);
	assign OUT_STALL_O = stall(OUT_VALID_O, OUT_READY_I);

endmodule

// *** verif/hsp_sink_model.sv ***
// Consumer model that drives ready on the pipeline output.
// Assumes the bench supplies a mode and a random bit.
`timescale 1ns/1ps

module hsp_sink_model (
	input  wire logic       clk_i,
	input  wire logic [1:0] mode_i,
	input  wire logic       rnd_i,
	output logic            ready_o = 1'b0
);
	// Mode 0 takes always, 1 at random, 2 stalls; ready never waits for valid.
	always @(negedge clk_i) begin
		ready_o <= mode_i == 2'h0 || (mode_i == 2'h1 && rnd_i);
	end
endmodule

// *** verif/hsp_pipeline_asserts.sv ***
// Handshake checks on the pipeline top ports.
// Assumes one clock and an active-high reset.
`timescale 1ns/1ps

module hsp_chk
	import hsp_pkg::*;
#(
	parameter int unsigned W = HSP_DATA_W
) (
	input wire logic         CORE_CLK_I,
	input wire logic         RST_I,
	input wire hsp_path_t    PATH_SEL_I,
	input wire logic         HALT_I,
	input wire logic         DROP_I,
	input wire logic         IN_VALID_I,
	input wire logic         IN_READY_O,
	input wire logic [W-1:0] IN_DATA_I,
	input wire logic         OUT_VALID_O,
	input wire logic         OUT_READY_I,
	input wire logic [W-1:0] OUT_DATA_O,
	input wire logic         IN_FIRE_O,
	input wire logic         IN_STALL_O,
	input wire logic         OUT_FIRE_O,
	input wire logic         OUT_STALL_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	// Paths whose output comes from flops; the others may follow the input.
	wire reg_path = PATH_SEL_I inside {HSP_PATH_FORWARD, HSP_PATH_HALF,
		HSP_PATH_COMBINED, HSP_PATH_QUEUED};
	////////////////////////////////////////
	chk_in_flags: assert property (IN_FIRE_O == (IN_VALID_I && IN_READY_O) &&
		IN_STALL_O == (IN_VALID_I && !IN_READY_O)) else $error("input flags wrong");
	chk_out_flags: assert property (OUT_FIRE_O == (OUT_VALID_O && OUT_READY_I) &&
		OUT_STALL_O == (OUT_VALID_O && !OUT_READY_I)) else $error("output flags wrong");
	chk_reset_clear: assert property ($fell(RST_I) && reg_path |-> !OUT_VALID_O)
		else $error("valid left after reset");
	chk_fwd_load: assert property (PATH_SEL_I == HSP_PATH_FORWARD && IN_FIRE_O && !DROP_I
		|=> OUT_VALID_O && OUT_DATA_O == $past(IN_DATA_I)) else $error("forward slice late");
	chk_out_hold: assert property (OUT_STALL_O && reg_path
		|=> OUT_VALID_O && $stable(OUT_DATA_O)) else $error("stalled output moved");
	chk_half_gap: assert property (PATH_SEL_I == HSP_PATH_HALF && IN_FIRE_O
		|=> !IN_READY_O) else $error("half slice took two in a row");
	chk_halt_block: assert property (HALT_I |-> !IN_READY_O)
		else $error("ready while halted");
	chk_drop_take: assert property (DROP_I && !HALT_I |-> IN_READY_O)
		else $error("drop gate not taking");
	chk_bwd_pass: assert property (PATH_SEL_I == HSP_PATH_BACKWARD && IN_FIRE_O && !DROP_I
		|-> OUT_VALID_O && OUT_DATA_O == IN_DATA_I) else $error("backward slice delayed");
endmodule

bind hsp_pipeline hsp_chk #(.W(W)) u_hsp_chk (.*);

// *** verif/hsp_pipeline_test.sv ***
// Self-checking bench: random producer, queue model, consumer model.
// Assumes the sink model and checker are compiled first.
`timescale 1ns/1ps

module hsp_pipeline_test
	import hsp_pkg::*;
;
	logic        CORE_CLK_I = 1'b0, RST_I = 1'b1, HALT_I = 1'b0, DROP_I = 1'b0;
	logic        IN_VALID_I = 1'b0, OUT_READY_I, prod_on = 1'b0, fired = 1'b0;
	logic        IN_READY_O, OUT_VALID_O, IN_FIRE_O, IN_STALL_O, OUT_FIRE_O, OUT_STALL_O;
	logic [7:0]  IN_DATA_I = 8'h00, OUT_DATA_O;
	hsp_path_t   PATH_SEL_I = HSP_PATH_DIRECT;
	logic [15:0] lf = 16'h004B;
	logic [1:0]  mode = 2'h2;
	int          failures = 0, checks = 0;
	logic [7:0]  exp_q[$];

	always #2.5 CORE_CLK_I = ~CORE_CLK_I;
	hsp_pipeline u_hsp_pipeline (.*);
	hsp_sink_model u_hsp_sink_model (.clk_i(CORE_CLK_I), .mode_i(mode), .rnd_i(lf[15]),
		.ready_o(OUT_READY_I));
	////////////////////////////////////////
	function automatic logic [15:0] nxt(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			failures++;
			$display("wrong value at %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic run(input int n, input hsp_path_t p, input logic [1:0] m);
		PATH_SEL_I = p;
		mode <= m;
		prod_on <= 1'b1;
		repeat (n) @(negedge CORE_CLK_I);
		if (m == 2'h2 || HALT_I) begin
			chk(8'(IN_READY_O), 8'h00);
		end
		if (HALT_I || DROP_I) begin
			chk(8'(OUT_VALID_O), 8'h00);
		end
		HALT_I = 1'b0;
		DROP_I = 1'b0;
		prod_on <= 1'b0;
		mode <= 2'h0;
		repeat (20) @(negedge CORE_CLK_I);
		chk(8'(exp_q.size()), 8'h00);
		$display("test path %0d mode %0d done", p, m);
	endtask
	////////////////////////////////////////
	// The producer holds a word until it is taken, so nothing is lost to a stall.
	always @(negedge CORE_CLK_I) begin
		lf <= nxt(lf);
		if (!IN_VALID_I || fired) begin
			IN_VALID_I = prod_on & lf[0];
			IN_DATA_I = lf[8:1];
		end
	end
	// Sampling just ahead of the rising edge sees settled values, free of any race
	// with the flops that the edge itself updates.
	always @(negedge CORE_CLK_I) begin
		#2;
		fired = IN_VALID_I && IN_READY_O;
		if (fired && !DROP_I && !RST_I) begin
			exp_q.push_back(IN_DATA_I);
		end
		if (OUT_VALID_O && OUT_READY_I && !RST_I) begin
			chk(OUT_DATA_O, exp_q.size() ? exp_q.pop_front() : 8'hXX);
		end
	end
	initial begin
		repeat (2) @(posedge CORE_CLK_I);
		@(negedge CORE_CLK_I);
		RST_I = 1'b0;
		for (int p = 0; p < 6; p++) begin
			for (int m = 0; m < 2; m++) begin
				run(40, hsp_path_t'(p), 2'(m));
			end
		end
		run(24, HSP_PATH_QUEUED, 2'h2);
		HALT_I = 1'b1;
		run(10, HSP_PATH_DIRECT, 2'h0);
		DROP_I = 1'b1;
		run(20, HSP_PATH_FORWARD, 2'h1);
		PATH_SEL_I = HSP_PATH_COMBINED;
		prod_on <= 1'b1;
		repeat (10) @(negedge CORE_CLK_I);
		RST_I = 1'b1;
		repeat (2) @(negedge CORE_CLK_I);
		exp_q.delete();
		chk(8'(OUT_VALID_O), 8'h00);
		RST_I = 1'b0;
		run(20, HSP_PATH_COMBINED, 2'h1);
		wrap_up();
	end
	initial begin
		#(5 * 3000);
		failures++;
		wrap_up();
	end
endmodule
